// ==== hdl/pvc_regs.svh ====
// command codes, reset values and timing constants of the voltage configuration bank
// --------------------------------------------------------------------------
// Notes on behaviour
// - ceiling word in output-voltage format, never above 110 percent of strap; reset loads ffff and a write on the first clock after reset is not capped
// - margin-up target word applies while margin high is selected
// - margin-down target word applies while margin low is selected
// - output reference ramps at slew word rate in volts per millisecond
// - load-line slope word in mV per amp gives the droop
// - sense loop gain held as a writable direct-format word
// - sense monitor scale held as a writable direct-format word
// - duty cycle clamped to the percentage held in the limit word
// - switching frequency taken in kilohertz, one kilohertz steps
// - conversion starts when input voltage reaches turn-on level
// - running conversion stops when input falls to turn-off level
// - group identifier held in bits 11 to 8 of phase word
// - unit count of group held in bits 7 to 4
// - bits 3 to 0 give phase order; clock source gets zero
// - linear offset in amps added to output current readings
// - over-voltage threshold word in output-voltage format
// - all words are read whole; all but current offset are written, phase word bits 15 to 12 stay zero
// - voltage mode bits 7 to 5; 000 is linear, exponent bits 4 to 0
// --------------------------------------------------------------------------
`ifndef PVC_REGS_SVH
`define PVC_REGS_SVH

`define PVC_CMD_CEILING 8'h24
`define PVC_CMD_MARGIN_UP 8'h25
`define PVC_CMD_MARGIN_DOWN 8'h26
`define PVC_CMD_SLEW 8'h27
`define PVC_CMD_LOAD_LINE 8'h28
`define PVC_CMD_LOOP_GAIN 8'h29
`define PVC_CMD_MON_SCALE 8'h2a
`define PVC_CMD_DUTY_LIMIT 8'h32
`define PVC_CMD_SW_RATE 8'h33
`define PVC_CMD_TURN_ON 8'h35
`define PVC_CMD_TURN_OFF 8'h36
`define PVC_CMD_PHASE_GROUP 8'h37
`define PVC_CMD_CUR_OFFSET 8'h39
`define PVC_CMD_OV_LIMIT 8'h40

`define PVC_GROUP_MSB 11
`define PVC_GROUP_LSB 8
`define PVC_COUNT_MSB 7
`define PVC_COUNT_LSB 4
`define PVC_POS_MSB 3
`define PVC_POS_LSB 0
`define PVC_LIN_EXP_MSB 15
`define PVC_LIN_EXP_LSB 11
`define PVC_LIN_MAN_MSB 10
`define PVC_MODE_MSB 7
`define PVC_MODE_LSB 5
`define PVC_MODE_EXP_MSB 4
`define PVC_MODE_LINEAR 3'h0

`define PVC_RST_WORD 16'h0000
`define PVC_RST_SLEW 16'h0001
`define PVC_RST_DUTY 16'h0032
`define PVC_RST_RATE 16'h00c8
`define PVC_RST_OV 16'hffff

`define PVC_CEIL_PCT 110
`define PVC_CLK_NS 10
`define PVC_SLEW_TICK_NS 1000000
`define PVC_MV_PER_V 1000

`endif

// ==== hdl/pvc_pkg.sv ====
// types shared by the voltage configuration bank
package pvc_pkg;

  typedef enum logic [1:0] {
    PVC_MARGIN_NONE = 2'b00,
    PVC_MARGIN_UP = 2'b01,
    PVC_MARGIN_DOWN = 2'b10
  } pvc_margin_t;

  typedef enum logic {
    PVC_CONV_IDLE = 1'b0,
    PVC_CONV_RUN = 1'b1
  } pvc_conv_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } pvc_cmd_t;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] rdata;
  } pvc_rsp_t;

  typedef struct packed {
    logic [3:0] group_id;
    logic [3:0] unit_count;
    logic [3:0] position;
  } pvc_phase_t;

endpackage

// ==== hdl/pvc_vout_config.sv ====
// configuration command bank: storage, word access and the logic each word steers
`include "pvc_regs.svh"

module pvc_vout_config #(
  parameter int unsigned SLEW_TICK_CYCLES = `PVC_SLEW_TICK_NS / `PVC_CLK_NS,
  parameter logic [15:0] CUR_OFFSET_RST = 16'h0000
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire pvc_pkg::pvc_cmd_t cmd_i,
  input wire logic [7:0] vout_mode_i,
  input wire logic [15:0] vout_strap_i,
  input wire logic [15:0] vout_nominal_i,
  input wire pvc_pkg::pvc_margin_t margin_sel_i,
  input wire logic [15:0] vout_meas_i,
  input wire logic [15:0] vin_volts_i,
  input wire logic signed [15:0] output_current_reading_raw_i,
  input wire logic [15:0] duty_req_i,
  output pvc_pkg::pvc_rsp_t rsp_o,
  output logic [15:0] vout_ref_o,
  output logic [15:0] vout_ceiling_o,
  output logic [31:0] droop_mv_o,
  output logic [15:0] loop_gain_o,
  output logic [15:0] monitor_scale_o,
  output logic [15:0] duty_o,
  output logic [15:0] freq_khz_o,
  output logic conv_en_o,
  output pvc_pkg::pvc_phase_t phase_o,
  output logic signed [15:0] output_current_reading_o,
  output logic ov_fault_o,
  output logic mode_err_o
);
  import pvc_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ceiling;
    logic [15:0] margin_up;
    logic [15:0] margin_down;
    logic [15:0] slew;
    logic [15:0] load_line;
    logic [15:0] loop_gain;
    logic [15:0] mon_scale;
    logic [15:0] duty_limit;
    logic [15:0] sw_rate;
    logic [15:0] turn_on;
    logic [15:0] turn_off;
    logic [15:0] phase_group;
    logic [15:0] cur_offset;
    logic [15:0] ov_limit;
    logic strap_taken;
    logic [15:0] strap_cap;
    logic [16:0] tick_cnt;
    logic [15:0] ref_now;
    pvc_conv_t conv;
    pvc_rsp_t rsp;
    logic [31:0] droop;
    logic [15:0] duty;
    logic [15:0] freq;
    logic signed [15:0] output_current_reading;
    logic ov;
    logic mode_err;
  } pvc_state_t;

  pvc_state_t st;
  pvc_state_t next_st;

  localparam logic [16:0] TICK_LAST = 17'(SLEW_TICK_CYCLES - 1);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // linear word to integer, scaled by 2^bias; fraction bits are dropped
  function automatic logic signed [31:0] lin_value(input logic [15:0] w,
                                                  input logic signed [6:0] bias);
    logic signed [6:0] e;
    logic signed [31:0] m;
    e = 7'(signed'(w[`PVC_LIN_EXP_MSB:`PVC_LIN_EXP_LSB])) + bias;
    m = 32'(signed'(w[`PVC_LIN_MAN_MSB:0]));
    if (e >= 7'sd20) begin
      lin_value = m <<< 20;
    end else if (e >= 7'sd0) begin
      lin_value = m <<< e;
    end else if (e > -7'sd31) begin
      lin_value = m >>> (-e);
    end else begin
      lin_value = (m < 0) ? -32'sd1 : 32'sd0;
    end
  endfunction

  // clamp a signed result into an unsigned 16-bit field
  function automatic logic [15:0] sat_u16(input logic signed [31:0] v);
    if (v < 0) begin
      sat_u16 = 16'h0000;
    end else if (v > 32'sh0000_ffff) begin
      sat_u16 = 16'hffff;
    end else begin
      sat_u16 = v[15:0];
    end
  endfunction

  function automatic logic [15:0] min_u16(input logic [15:0] a, input logic [15:0] b);
    min_u16 = (a < b) ? a : b;
  endfunction

  // linear word as a whole number, negative values read as zero
  function automatic logic [15:0] lin_u16(input logic [15:0] w);
    lin_u16 = sat_u16(lin_value(w, 7'sd0));
  endfunction

  // clamp a signed sum into a signed 16-bit reading
  function automatic logic signed [15:0] sat_s16(input logic signed [31:0] v);
    if (v > 32'sh0000_7fff) begin
      sat_s16 = 16'sh7fff;
    end else if (v < -32'sh0000_8000) begin
      sat_s16 = 16'sh8000;
    end else begin
      sat_s16 = v[15:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic linear_mode;
  logic signed [6:0] vexp;
  logic [15:0] target;
  logic [15:0] step;
  logic [16:0] cap_calc;
  logic [15:0] wr_val;
  logic signed [31:0] output_current_reading_sum;
  logic [15:0] vin_on_v;
  logic [15:0] vin_off_v;

  always_comb begin
    next_st = st;
    linear_mode = (vout_mode_i[`PVC_MODE_MSB:`PVC_MODE_LSB] == `PVC_MODE_LINEAR);
    vexp = 7'(signed'(vout_mode_i[`PVC_MODE_EXP_MSB:0]));
    // full strap range times 110 needs 23 bits before the divide
    cap_calc = 17'((24'(vout_strap_i) * 24'(`PVC_CEIL_PCT)) / 24'd100);
    wr_val = cmd_i.wdata;
    target = 16'h0000;
    step = 16'h0000;
    output_current_reading_sum = 32'sd0;
    vin_on_v = lin_u16(st.turn_on);
    vin_off_v = lin_u16(st.turn_off);

    // ------------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------------
    // strap is sampled on the first clock after reset release
    if (!st.strap_taken) begin
      next_st.strap_taken = 1'b1;
      next_st.strap_cap = cap_calc[16] ? 16'hffff : cap_calc[15:0];
      next_st.ceiling = min_u16(st.ceiling, next_st.strap_cap);
    end

    // ------------------------------------------------------------------------
    // word access
    // ------------------------------------------------------------------------
    next_st.rsp.valid = cmd_i.valid;
    next_st.rsp.ack = 1'b0;
    next_st.rsp.rdata = 16'h0000;
    if (cmd_i.valid) begin
      next_st.rsp.ack = 1'b1;
      // reads always return the whole stored word
      if (cmd_i.code == `PVC_CMD_CEILING) begin
        next_st.rsp.rdata = st.ceiling;
        if (cmd_i.write) begin
          next_st.ceiling = min_u16(wr_val, st.strap_cap);
        end
      end else if (cmd_i.code == `PVC_CMD_MARGIN_UP) begin
        next_st.rsp.rdata = st.margin_up;
        if (cmd_i.write) begin
          next_st.margin_up = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_MARGIN_DOWN) begin
        next_st.rsp.rdata = st.margin_down;
        if (cmd_i.write) begin
          next_st.margin_down = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_SLEW) begin
        next_st.rsp.rdata = st.slew;
        if (cmd_i.write) begin
          next_st.slew = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_LOAD_LINE) begin
        next_st.rsp.rdata = st.load_line;
        if (cmd_i.write) begin
          next_st.load_line = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_LOOP_GAIN) begin
        next_st.rsp.rdata = st.loop_gain;
        if (cmd_i.write) begin
          next_st.loop_gain = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_MON_SCALE) begin
        next_st.rsp.rdata = st.mon_scale;
        if (cmd_i.write) begin
          next_st.mon_scale = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_DUTY_LIMIT) begin
        next_st.rsp.rdata = st.duty_limit;
        if (cmd_i.write) begin
          next_st.duty_limit = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_SW_RATE) begin
        next_st.rsp.rdata = st.sw_rate;
        if (cmd_i.write) begin
          next_st.sw_rate = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_TURN_ON) begin
        next_st.rsp.rdata = st.turn_on;
        if (cmd_i.write) begin
          next_st.turn_on = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_TURN_OFF) begin
        next_st.rsp.rdata = st.turn_off;
        if (cmd_i.write) begin
          next_st.turn_off = wr_val;
        end
      end else if (cmd_i.code == `PVC_CMD_PHASE_GROUP) begin
        // upper nibble is not a field and stays zero
        next_st.rsp.rdata = st.phase_group;
        if (cmd_i.write) begin
          next_st.phase_group = {4'h0, wr_val[11:0]};
        end
      end else if (cmd_i.code == `PVC_CMD_CUR_OFFSET) begin
        next_st.rsp.rdata = st.cur_offset;
        if (cmd_i.write) begin
          next_st.rsp.ack = 1'b0;
        end
      end else if (cmd_i.code == `PVC_CMD_OV_LIMIT) begin
        next_st.rsp.rdata = st.ov_limit;
        if (cmd_i.write) begin
          next_st.ov_limit = wr_val;
        end
      end else begin
        // unknown codes are refused and read as zero
        next_st.rsp.ack = 1'b0;
      end
    end

    // ------------------------------------------------------------------------
    // margin target
    // ------------------------------------------------------------------------
    case (margin_sel_i)
      PVC_MARGIN_UP: target = st.margin_up;
      PVC_MARGIN_DOWN: target = st.margin_down;
      default: target = vout_nominal_i;
    endcase
    // clamping the target first means a lowered ceiling pulls the reference down too
    target = min_u16(target, st.ceiling);

    // ------------------------------------------------------------------------
    // slew ramp
    // ------------------------------------------------------------------------
    // step is the slew in output-voltage units; a zero step still moves one count
    step = sat_u16(lin_value(st.slew, -vexp));
    if (step == 16'h0000) begin
      step = 16'h0001;
    end
    next_st.mode_err = !linear_mode;
    // one tick is a millisecond at the default rate, so the step is output-voltage units per tick
    if (st.tick_cnt >= TICK_LAST) begin
      next_st.tick_cnt = 17'h0_0000;
      // a non-linear mode holds the reference: its units cannot be interpreted
      if (linear_mode) begin
        if (st.ref_now < target) begin
          if ((target - st.ref_now) > step) begin
            next_st.ref_now = st.ref_now + step;
          end else begin
            next_st.ref_now = target;
          end
        end else if (st.ref_now > target) begin
          if ((st.ref_now - target) > step) begin
            next_st.ref_now = st.ref_now - step;
          end else begin
            next_st.ref_now = target;
          end
        end
      end
    end else begin
      next_st.tick_cnt = st.tick_cnt + 17'h0_0001;
    end

    // ------------------------------------------------------------------------
    // load line and current reading
    // ------------------------------------------------------------------------
    output_current_reading_sum = 32'(output_current_reading_raw_i) + lin_value(st.cur_offset, 7'sd0);
    next_st.droop = 32'(lin_value(st.load_line, 7'sd0) * output_current_reading_sum);
    // the reading saturates rather than wraps when the offset pushes it out of range
    next_st.output_current_reading = sat_s16(output_current_reading_sum);

    // ------------------------------------------------------------------------
    // duty and frequency
    // ------------------------------------------------------------------------
    next_st.duty = min_u16(duty_req_i, lin_u16(st.duty_limit));
    next_st.freq = lin_u16(st.sw_rate);

    // ------------------------------------------------------------------------
    // input turn-on / turn-off with hysteresis
    // ------------------------------------------------------------------------
    // equal levels give no hysteresis and the converter may chatter at the threshold
    case (st.conv)
      PVC_CONV_IDLE: begin
        if (vin_volts_i >= vin_on_v) begin
          next_st.conv = PVC_CONV_RUN;
        end
      end
      PVC_CONV_RUN: begin
        if (vin_volts_i <= vin_off_v) begin
          next_st.conv = PVC_CONV_IDLE;
        end
      end
      default: next_st.conv = PVC_CONV_IDLE;
    endcase

    // ------------------------------------------------------------------------
    // over-voltage compare
    // ------------------------------------------------------------------------
    // strictly above: a reading equal to the limit is not a fault
    next_st.ov = (vout_meas_i > st.ov_limit);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      // words with no defined default start from the common reset word
      st.margin_up <= `PVC_RST_WORD;
      st.margin_down <= `PVC_RST_WORD;
      st.load_line <= `PVC_RST_WORD;
      st.loop_gain <= `PVC_RST_WORD;
      st.mon_scale <= `PVC_RST_WORD;
      st.turn_on <= `PVC_RST_WORD;
      st.turn_off <= `PVC_RST_WORD;
      st.phase_group <= `PVC_RST_WORD;
      st.slew <= `PVC_RST_SLEW;
      st.duty_limit <= `PVC_RST_DUTY;
      st.sw_rate <= `PVC_RST_RATE;
      st.ov_limit <= `PVC_RST_OV;
      st.ceiling <= 16'hffff;
      st.strap_cap <= 16'hffff;
      st.cur_offset <= CUR_OFFSET_RST;
      st.conv <= PVC_CONV_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign rsp_o = st.rsp;
  assign vout_ref_o = st.ref_now;
  assign vout_ceiling_o = st.ceiling;
  assign droop_mv_o = st.droop;
  assign loop_gain_o = st.loop_gain;
  assign monitor_scale_o = st.mon_scale;
  assign duty_o = st.duty;
  assign freq_khz_o = st.freq;
  assign conv_en_o = (st.conv == PVC_CONV_RUN);
  // position 0 is the unit that drives the shared sync clock
  assign phase_o.group_id = st.phase_group[`PVC_GROUP_MSB:`PVC_GROUP_LSB];
  assign phase_o.unit_count = st.phase_group[`PVC_COUNT_MSB:`PVC_COUNT_LSB];
  assign phase_o.position = st.phase_group[`PVC_POS_MSB:`PVC_POS_LSB];
  assign output_current_reading_o = st.output_current_reading;
  assign ov_fault_o = st.ov;
  assign mode_err_o = st.mode_err;

endmodule

// ==== tb/pvc_cfg_properties.sv ====
// port assertions of the voltage configuration bank
module pvc_cfg_properties #(
  parameter logic [15:0] CUR_OFFSET_RST = 16'h0000
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire pvc_pkg::pvc_cmd_t cmd_i,
  input wire logic [7:0] vout_mode_i,
  input wire logic [15:0] vout_strap_i,
  input wire logic signed [15:0] output_current_reading_raw_i,
  input wire logic [15:0] duty_req_i,
  input wire pvc_pkg::pvc_rsp_t rsp_o,
  input wire logic [15:0] vout_ref_o,
  input wire logic [15:0] vout_ceiling_o,
  input wire logic [15:0] loop_gain_o,
  input wire logic [15:0] monitor_scale_o,
  input wire logic [15:0] duty_o,
  input wire pvc_pkg::pvc_phase_t phase_o,
  input wire logic signed [15:0] output_current_reading_o,
  input wire logic mode_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pvc_pkg::*;
  logic [1:0] age;
  logic warm;
  logic wr_any;
  logic [11:0] wd_low;
  logic [31:0] cap_full;
  // ----
  // helpers
  // ----
  // strap is captured on the first edge after release, so the cap holds from the third on, but a ceiling write on that first edge is not capped
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  assign warm = (age == 2'h3);
  assign wr_any = cmd_i.valid && cmd_i.write;
  assign wd_low = cmd_i.wdata[11:0];
  assign cap_full = ({16'h0000, vout_strap_i} * 32'h0000_006e) / 32'h0000_0064;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // properties
  // ----
  chk_rsp_follows: assert property (cmd_i.valid |=> rsp_o.valid)
    else $error("no response after command");
  chk_rsp_cause: assert property (rsp_o.valid |-> $past(cmd_i.valid))
    else $error("response without command");
  chk_ro_refused: assert property (wr_any && cmd_i.code == 8'h39 |=> !rsp_o.ack)
    else $error("read-only write acknowledged");
  chk_phase_store: assert property (
    wr_any && cmd_i.code == 8'h37 |=> phase_o == $past(wd_low))
    else $error("phase fields not taken from written word");
  chk_gain_store: assert property (
    wr_any && cmd_i.code == 8'h29 |=> loop_gain_o == $past(cmd_i.wdata))
    else $error("loop gain not stored");
  chk_scale_store: assert property (
    wr_any && cmd_i.code == 8'h2a |=> monitor_scale_o == $past(cmd_i.wdata))
    else $error("monitor scale not stored");
  chk_ceiling_cap: assert property (warm |-> {16'h0000, vout_ceiling_o} <= cap_full)
    else $error("ceiling above strap margin");
  chk_duty_clamp: assert property (warm |-> duty_o <= $past(duty_req_i))
    else $error("duty above request");
  chk_output_current_reading_offset: assert property (
    warm && CUR_OFFSET_RST == 16'h0000 |-> output_current_reading_o == $past(output_current_reading_raw_i))
    else $error("current reading offset wrong");
  chk_mode_flag: assert property (
    $stable(vout_mode_i) |-> mode_err_o == (vout_mode_i[7:5] != 3'h0))
    else $error("mode flag wrong");
  chk_ref_hold: assert property (
    warm && $stable(vout_mode_i) && vout_mode_i[7:5] != 3'h0 |-> $stable(vout_ref_o))
    else $error("reference moved in non-linear mode");
  cov_ro_write: cover property (wr_any && cmd_i.code == 8'h39);
  cov_refused: cover property (rsp_o.valid && !rsp_o.ack);
  cov_mode_bad: cover property (mode_err_o);
endmodule

// ==== tb/pvc_host_model.sv ====
// word-transfer host on the command side of the bank
module pvc_host_model (
  input wire logic mclk_i,
  input wire pvc_pkg::pvc_rsp_t rsp_i,
  output pvc_pkg::pvc_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pvc_pkg::*;
  initial cmd_o = '0;
  // ----
  // transfer
  // ----
  // one whole word per request; after release the fields carry inverted junk, never stale data
  task automatic do_cmd(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
      output logic ack, output logic [15:0] rdata, output logic seen);
    @(posedge mclk_i);
    cmd_o <= '{valid: 1'b1, write: wr, code: code, wdata: wdata};
    @(posedge mclk_i);
    cmd_o <= '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~wdata};
    @(posedge mclk_i);
    seen = rsp_i.valid;
    ack = rsp_i.ack;
    rdata = rsp_i.rdata;
  endtask
endmodule

// ==== tb/test_pvc_vout_config.sv ====
// self-checking bench of the voltage configuration bank
module test_pvc_vout_config;
  timeunit 1ns;
  timeprecision 1ps;
  import pvc_pkg::*;
  localparam logic [15:0] STRAP = 16'h0100;
  localparam logic [7:0] CODES [14] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a,
    8'h32, 8'h33, 8'h35, 8'h36, 8'h37, 8'h39, 8'h40};
  localparam logic [15:0] VINS [5] = '{16'h001e, 16'h0028, 16'h0024, 16'h0022, 16'h0024};
  localparam logic [4:0] ONS = 5'b00110;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pvc_cmd_t cmd_i;
  pvc_rsp_t rsp_o;
  pvc_margin_t margin_sel_i = PVC_MARGIN_NONE;
  pvc_phase_t phase_o;
  logic [7:0] vout_mode_i = 8'h00;
  logic [15:0] vout_meas_i = 16'h0000;
  logic [15:0] vin_volts_i = 16'h0000;
  logic [15:0] duty_req_i = 16'h0000;
  logic signed [15:0] output_current_reading_raw_i = 16'sh0000;
  logic [15:0] vout_ref_o, vout_ceiling_o, loop_gain_o, monitor_scale_o, duty_o, freq_khz_o;
  logic [31:0] droop_mv_o;
  logic conv_en_o, ov_fault_o, mode_err_o, ack, seen;
  logic signed [15:0] output_current_reading_o;
  logic [15:0] rd, d;
  logic [15:0] rstv [14];
  int n_errors = 0;
  int total_checks = 0;
  int r;
  always #5 mclk_i = ~mclk_i;
  pvc_vout_config #(.SLEW_TICK_CYCLES(4), .CUR_OFFSET_RST(16'h0000)) pvc_vout_config_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .vout_mode_i(vout_mode_i),
    .vout_strap_i(STRAP), .vout_nominal_i(16'h0000), .margin_sel_i(margin_sel_i),
    .vout_meas_i(vout_meas_i), .vin_volts_i(vin_volts_i), .output_current_reading_raw_i(output_current_reading_raw_i),
    .duty_req_i(duty_req_i), .rsp_o(rsp_o), .vout_ref_o(vout_ref_o),
    .vout_ceiling_o(vout_ceiling_o), .droop_mv_o(droop_mv_o), .loop_gain_o(loop_gain_o),
    .monitor_scale_o(monitor_scale_o), .duty_o(duty_o), .freq_khz_o(freq_khz_o),
    .conv_en_o(conv_en_o), .phase_o(phase_o), .output_current_reading_o(output_current_reading_o), .ov_fault_o(ov_fault_o),
    .mode_err_o(mode_err_o));
  pvc_host_model pvc_host_model_inst (.mclk_i(mclk_i), .rsp_i(rsp_o), .cmd_o(cmd_i));
  // ----
  // helpers
  // ----
  function automatic logic [15:0] cap(input logic [15:0] s);
    int c;
    c = (int'(s) * 110) / 100;
    return (c > 65535) ? 16'hffff : 16'(c);
  endfunction
  // fractions drop toward minus infinity, as the arithmetic shift does
  function automatic int lin(input logic [15:0] w);
    int m;
    int e;
    m = int'($signed(w[10:0]));
    e = int'($signed(w[15:11]));
    return (e >= 0) ? (m <<< e) : (m >>> -e);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    pvc_host_model_inst.do_cmd(1'b1, c, v, ack, rd, seen);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e, input logic ea);
    pvc_host_model_inst.do_cmd(1'b0, c, 16'h0000, ack, rd, seen);
    chk({31'h0000_0000, seen}, 32'h0000_0001);
    chk({31'h0000_0000, ack}, {31'h0000_0000, ea});
    chk({16'h0000, rd}, {16'h0000, e});
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    rstv = '{cap(STRAP), 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
      16'h0032, 16'h00c8, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff};
    r = $urandom(14678);
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(2);
    for (int i = 0; i < 14; i++) begin
      rdc(CODES[i], rstv[i], 1'b1);
    end
    for (int i = 1; i < 14; i++) begin
      if (i != 12) begin
        d = 16'($urandom);
        wr(CODES[i], d);
        rdc(CODES[i], (i == 11) ? {4'h0, d[11:0]} : d, 1'b1);
      end
    end
    wr(8'h37, 16'hf5a0);
    chk({20'h0_0000, phase_o}, 32'h0000_05a0);
    pvc_host_model_inst.do_cmd(1'b1, 8'h39, 16'h1234, ack, rd, seen);
    chk({31'h0000_0000, ack}, 32'h0000_0000);
    rdc(8'h39, 16'h0000, 1'b1);
    rdc(8'h30, 16'h0000, 1'b0);
    wr(8'h24, 16'hffff);
    rdc(8'h24, cap(STRAP), 1'b1);
    wr(8'h24, 16'h0014);
    wr(8'h27, 16'h0001);
    wr(8'h25, 16'h0030);
    wr(8'h26, 16'h0008);
    margin_sel_i <= PVC_MARGIN_UP;
    cyc(20);
    chk({31'h0000_0000, vout_ref_o <= 16'h0006}, 32'h0000_0001);
    cyc(100);
    chk({16'h0000, vout_ref_o}, 32'h0000_0014);
    margin_sel_i <= PVC_MARGIN_DOWN;
    cyc(100);
    chk({16'h0000, vout_ref_o}, 32'h0000_0008);
    wr(8'h27, 16'h0808);
    margin_sel_i <= PVC_MARGIN_UP;
    cyc(10);
    chk({16'h0000, vout_ref_o}, 32'h0000_0014);
    // a non-linear mode must freeze the reference even with a new target selected
    vout_mode_i <= 8'h20;
    margin_sel_i <= PVC_MARGIN_DOWN;
    cyc(20);
    chk({31'h0000_0000, mode_err_o}, 32'h0000_0001);
    chk({16'h0000, vout_ref_o}, 32'h0000_0014);
    vout_mode_i <= 8'h00;
    wr(8'h32, 16'hf8c8);
    for (int k = 0; k < 8; k++) begin
      r = (k == 0) ? 100 : (k == 1) ? 101 : int'($urandom_range(200));
      duty_req_i <= 16'(r);
      cyc(3);
      chk({16'h0000, duty_o}, (r > lin(16'hf8c8)) ? lin(16'hf8c8) : r);
    end
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 16'h08c8 : 16'h0191;
      wr(8'h33, d);
      cyc(2);
      chk({16'h0000, freq_khz_o}, lin(d));
    end
    wr(8'h35, 16'h0028);
    wr(8'h36, 16'h0022);
    for (int k = 0; k < 5; k++) begin
      vin_volts_i <= VINS[k];
      cyc(3);
      chk({31'h0000_0000, conv_en_o}, {31'h0000_0000, ONS[k]});
    end
    wr(8'h28, 16'h0002);
    output_current_reading_raw_i <= 16'sh000a;
    cyc(4);
    chk(droop_mv_o, 32'h0000_0014);
    chk({16'h0000, output_current_reading_o}, 32'h0000_000a);
    output_current_reading_raw_i <= -16'sh0005;
    cyc(3);
    chk({16'h0000, output_current_reading_o}, 32'h0000_fffb);
    wr(8'h40, 16'h0050);
    vout_meas_i <= 16'h0051;
    cyc(3);
    chk({31'h0000_0000, ov_fault_o}, 32'h0000_0001);
    vout_meas_i <= 16'h0050;
    cyc(3);
    chk({31'h0000_0000, ov_fault_o}, 32'h0000_0000);
    print_verdict();
  end
  // the sequence needs well under two thousand cycles
  initial begin
    cyc(5000);
    n_errors++;
    print_verdict();
  end
endmodule

bind pvc_vout_config pvc_cfg_properties #(.CUR_OFFSET_RST(CUR_OFFSET_RST))
  pvc_cfg_properties_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .vout_mode_i(vout_mode_i),
  .vout_strap_i(vout_strap_i), .output_current_reading_raw_i(output_current_reading_raw_i), .duty_req_i(duty_req_i),
  .rsp_o(rsp_o), .vout_ref_o(vout_ref_o), .vout_ceiling_o(vout_ceiling_o),
  .loop_gain_o(loop_gain_o), .monitor_scale_o(monitor_scale_o), .duty_o(duty_o),
  .phase_o(phase_o), .output_current_reading_o(output_current_reading_o), .mode_err_o(mode_err_o));
